// File: hcs_homing_words.sv
// Homing-mode command word decode and status word assembly.
// Assumes all drive inputs are synchronous to clk; motion engine is outside.
//
// Contract
// - Halt bit 8 set stops motion using the halt option method.
// - Homing starts on a 0 to 1 edge of command bit 4.
// - Clearing bit 4 during homing decelerates the motor to stop.
// - Start edge ignored while moving, halted, or external stop active.
// - Start edge ignored unless operation enabled and motor excited.
// - Status bit 15 shows torque upper limit reached.
// - Status bits 13, 12, 10 form one homing status code.
// - Status bit 11 is set while any internal limit is active.
// - Status bit 9 sets once initialization completes.
// - Status bit 7 follows the warning cause, no acknowledge.
// - Codes: 000 running, 001 idle, 011 done, 101 alarm.
// - On homing completion the position preset to home offset fires.
`timescale 1ns/1ps
`include "hcs_defines.svh"
module hcs_homing_words
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] motion_command_word,
    output logic [15:0] motion_state_word,
    input wire logic op_enabled,
    input wire logic motor_excited,
    input wire logic motion_busy,
    input wire logic ext_stop,
    input wire logic home_found,
    input wire logic motion_stopped,
    input wire logic alarm,
    input wire logic torque_limit_reached,
    input wire logic forward_end_sensor,
    input wire logic reverse_end_sensor,
    input wire logic forward_motion_prohibit,
    input wire logic reverse_motion_prohibit,
    input wire logic soft_limit,
    input wire logic mech_limit,
    input wire logic init_done,
    input wire logic warning_cause,
    output logic home_go,
    output logic halt_stop,
    output logic home_decel,
    output logic preset_pulse
);
    import hcs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Command word
    // Only halt and start are stored; the other bits belong to the drive state machine
    logic [15:0] cw_r;
    wire [15:0] cw_nxt = cmd_wr ? (cmd_wdata & `HCS_CW_KEEP_MASK) : cw_r;
    wire start_lvl = cw_r[`HCS_CW_START_BIT];
    wire halt_lvl = cw_r[`HCS_CW_HALT_BIT];
    wire start_rise;

    hcs_edge u_start_edge
    (
        .clk(clk),
        .rst_b(rst_b),
        .level(start_lvl),
        .rise(start_rise)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cw_r <= `HCS_CW_RESET;
        else
            cw_r <= cw_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Homing sequencer
    hcs_state_e state_r;
    hcs_state_e state_nxt;
    hcs_home_code_t code_r;
    hcs_home_code_t code_nxt;
    logic preset_nxt;

    // A start edge seen outside IDLE is dropped, never queued
    wire start_ok = start_rise & ~motion_busy & ~halt_lvl & ~ext_stop
                  & op_enabled & motor_excited;
    wire in_run = (state_r == HCS_RUN);
    wire stop_req = ~start_lvl | halt_lvl | ext_stop | ~op_enabled;

    always_comb
    begin
        state_nxt = state_r;
        code_nxt = code_r;
        preset_nxt = 1'b0;
        case (state_r)
            HCS_IDLE:
            begin
                if (start_ok)
                begin
                    state_nxt = HCS_RUN;
                    code_nxt = `HCS_HS_RUNNING;
                end
            end
            HCS_RUN:
            begin
                if (alarm)
                begin
                    state_nxt = HCS_IDLE;
                    code_nxt = `HCS_HS_ALARM;
                end
                else if (stop_req)
                begin
                    // Stop is requested; code reports interrupted once motion ends
                    state_nxt = HCS_STOP;
                end
                else if (home_found)
                begin
                    state_nxt = HCS_IDLE;
                    code_nxt = `HCS_HS_DONE;
                    preset_nxt = 1'b1;
                end
            end
            HCS_STOP:
            begin
                // Alarm wins over a normal stop so the code says why motion ended
                if (alarm)
                begin
                    state_nxt = HCS_IDLE;
                    code_nxt = `HCS_HS_ALARM;
                end
                else if (motion_stopped)
                begin
                    state_nxt = HCS_IDLE;
                    code_nxt = `HCS_HS_IDLE;
                end
            end
            default:
            begin
                state_nxt = HCS_IDLE;
                code_nxt = `HCS_HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= HCS_IDLE;
            code_r <= `HCS_HS_IDLE;
            preset_pulse <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            preset_pulse <= preset_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Motion controls and status word
    wire limit_any = forward_end_sensor | reverse_end_sensor | forward_motion_prohibit
                   | reverse_motion_prohibit | soft_limit | mech_limit;
    logic init_seen_r;
    logic [15:0] sw_nxt;
    // Go and decel follow the next state so they line up with the status code; halt follows the next command word
    wire go_nxt = (state_nxt == HCS_RUN);
    wire halt_nxt = cw_nxt[`HCS_CW_HALT_BIT];
    // Also set on the alarm exit, so a cleared start bit always shows a decel cycle
    wire decel_nxt = (state_nxt == HCS_STOP) | (in_run & ~start_lvl);
    // Sticky: a single pulse on init_done is enough
    wire init_seen_nxt = init_seen_r | init_done;

    always_comb
    begin
        sw_nxt = 16'h0000;
        sw_nxt[`HCS_SW_TORQUE_BIT] = torque_limit_reached;
        sw_nxt[`HCS_SW_HERR_BIT] = code_nxt[2];
        sw_nxt[`HCS_SW_HATT_BIT] = code_nxt[1];
        sw_nxt[`HCS_SW_TGT_BIT] = code_nxt[0];
        sw_nxt[`HCS_SW_LIMIT_BIT] = limit_any;
        sw_nxt[`HCS_SW_REMOTE_BIT] = init_seen_nxt;
        sw_nxt[`HCS_SW_WARN_BIT] = warning_cause;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            init_seen_r <= 1'b0;
        else
            init_seen_r <= init_seen_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            motion_state_word <= 16'h0000;
            motion_command_word <= `HCS_CW_RESET;
        end
        else
        begin
            motion_state_word <= sw_nxt;
            motion_command_word <= cw_nxt;
        end
    end

    // Registered so the motion engine never sees a decode glitch
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            home_go <= 1'b0;
            halt_stop <= 1'b0;
            home_decel <= 1'b0;
        end
        else
        begin
            home_go <= go_nxt;
            halt_stop <= halt_nxt;
            home_decel <= decel_nxt;
        end
    end
endmodule

// File: hcs_defines.svh
// Constants for the homing command/status word logic.
// Assumes inclusion by bare name from the package and design files.
`ifndef HCS_DEFINES_SVH
`define HCS_DEFINES_SVH
`define HCS_CMD_WORD_INDEX 16'h6040
`define HCS_STS_WORD_INDEX 16'h6041
`define HCS_CW_START_BIT 4
`define HCS_CW_HALT_BIT 8
`define HCS_CW_KEEP_MASK 16'h0110
`define HCS_SW_TORQUE_BIT 15
`define HCS_SW_HERR_BIT 13
`define HCS_SW_HATT_BIT 12
`define HCS_SW_LIMIT_BIT 11
`define HCS_SW_TGT_BIT 10
`define HCS_SW_REMOTE_BIT 9
`define HCS_SW_WARN_BIT 7
`define HCS_CW_RESET 16'h0000
`define HCS_HS_RUNNING 3'b000
`define HCS_HS_IDLE 3'b001
`define HCS_HS_DONE 3'b011
`define HCS_HS_ALARM 3'b101
`endif

// File: hcs_pkg.sv
// Types for the homing command/status word logic.
// Assumes hcs_defines.svh is on the include path.
`include "hcs_defines.svh"
package hcs_pkg;
    typedef enum logic [1:0] {HCS_IDLE, HCS_RUN, HCS_STOP} hcs_state_e;
    typedef logic [2:0] hcs_home_code_t;
endpackage

// File: hcs_edge.sv
// Rising-edge detector for one synchronous level.
// Assumes the input is already in the clk domain.
`timescale 1ns/1ps
module hcs_edge
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic level,
    output logic rise
);
    logic level_r;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            level_r <= 1'b0;
        else
            level_r <= level;
    end
    assign rise = level & ~level_r;
endmodule

// File: hcs_homing_words_properties.sv
// Port checker for hcs_homing_words.
// Assumes the bind below reaches every instance.
`timescale 1ns/1ps
module hcs_homing_checker
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic op_enabled,
    input wire logic motor_excited,
    input wire logic motion_busy,
    input wire logic ext_stop,
    input wire logic [15:0] motion_command_word,
    input wire logic [15:0] motion_state_word,
    input wire logic torque_limit_reached,
    input wire logic forward_end_sensor,
    input wire logic reverse_end_sensor,
    input wire logic forward_motion_prohibit,
    input wire logic reverse_motion_prohibit,
    input wire logic soft_limit,
    input wire logic mech_limit,
    input wire logic init_done,
    input wire logic warning_cause,
    input wire logic home_go,
    input wire logic halt_stop,
    input wire logic home_decel,
    input wire logic preset_pulse
);
    wire logic [15:0] s = motion_state_word;
    wire logic [2:0] code = {s[13:12], s[10]};
    wire logic lim = forward_end_sensor | reverse_end_sensor | forward_motion_prohibit
        | reverse_motion_prohibit | soft_limit | mech_limit;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_halt_follow:
        assert property ($rose(motion_command_word[8]) |-> ##[0:1] halt_stop) else $error("halt");
    a_start_accept:
        assert property ($rose(motion_command_word[4]) && !halt_stop && op_enabled
            && motor_excited && !motion_busy && !ext_stop && !home_go && !home_decel
            |-> ##1 home_go) else $error("start accept");
    a_start_gate:
        assert property ($rose(home_go) |-> $past(op_enabled && motor_excited && !motion_busy
            && !ext_stop && !halt_stop)) else $error("start gate");
    a_stop_decel:
        assert property ($fell(motion_command_word[4]) && home_go |-> ##[0:1] home_decel)
        else $error("decel");
    a_level_bits:
        assert property ($past(rst_b) |-> {s[15], s[11], s[7]} ==
            $past({torque_limit_reached, lim, warning_cause})) else $error("levels");
    a_run_code:
        assert property (home_go |-> code == 3'b000) else $error("run code");
    a_ready_keep:
        assert property ($past(rst_b && (init_done || s[9])) |-> s[9]) else $error("ready");
    a_code_legal:
        assert property (code inside {3'b000, 3'b001, 3'b011, 3'b101}) else $error("code");
    a_preset_done:
        assert property (preset_pulse |-> code == 3'b011 ##1 !preset_pulse) else $error("preset");
    a_unused_zero:
        assert property ((motion_command_word & 16'hfeef) == 16'h0000 && !s[14])
        else $error("unused bits");
endmodule
bind hcs_homing_words hcs_homing_checker u_chk (.*);

// File: hcs_master.sv
// Fieldbus master model writing the command word.
// Assumes calls start just after a rising clk edge.
`timescale 1ns/1ps
module hcs_master
(
    input wire logic clk,
    output logic cmd_wr = 1'b0,
    output logic [15:0] cmd_wdata = 16'h0000
);
    // Start needs bit 4 written 0 then 1; the caller orders the words
    task automatic write(input logic [15:0] d);
        cmd_wdata = d;
        cmd_wr = 1'b1;
        @(posedge clk);
        #1 cmd_wr = 1'b0;
        // Released data is inverted so a stale word cannot pass
        cmd_wdata = ~d;
    endtask
endmodule

// File: test_homing_control_status_words.sv
// Bench for hcs_homing_words with the master model.
// Assumes the bound checker; expected words go through a queue.
`timescale 1ns/1ps
module test_homing_control_status_words;
    logic clk = 0, rst_b = 0, hf = 0, at_rest = 0, al = 0, ini = 0, wr_p, go, hs, dec, pre;
    logic eg = 0, eh = 0;
    logic [15:0] wd, cw, sw, e = 16'h0400;
    logic [3:0] en = 4'hc;
    logic [7:0] st = 0;
    logic [19:0] q[$], prev = 0, cur;
    int bad_count = 0, checks = 0, k;
    always #5 clk = ~clk;
    hcs_master u_m (.clk(clk), .cmd_wr(wr_p), .cmd_wdata(wd));
    hcs_homing_words uut (.clk(clk), .rst_b(rst_b), .cmd_wr(wr_p), .cmd_wdata(wd),
        .motion_command_word(cw), .motion_state_word(sw), .op_enabled(en[3]),
        .motor_excited(en[2]), .motion_busy(en[1]), .ext_stop(en[0]), .home_found(hf),
        .motion_stopped(at_rest), .alarm(al), .torque_limit_reached(st[7]),
        .forward_end_sensor(st[6]), .reverse_end_sensor(st[5]), .init_done(ini),
        .forward_motion_prohibit(st[4]), .reverse_motion_prohibit(st[3]), .soft_limit(st[2]),
        .mech_limit(st[1]), .warning_cause(st[0]), .home_go(go), .halt_stop(hs),
        .home_decel(dec), .preset_pulse(pre));
    task automatic cmp(input logic [19:0] g, input logic [19:0] x);
        checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("mismatch %0t %h %h", $time, g, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic note(input logic d, input logic p);
        q.push_back({eg, eh, d, p, e});
    endtask
    task automatic wr(input logic [15:0] d);
        u_m.write(d);
        cyc(2);
        cmp({4'h0, cw}, {4'h0, d & 16'h0110});
    endtask
    task automatic lvl;
        if ({st[7], |st[6:1], st[0]} != {e[15], e[11], e[7]})
        begin
            {e[15], e[11], e[7]} = {st[7], |st[6:1], st[0]};
            note(0, 0);
        end
        cyc(3);
    endtask
    task automatic report_and_stop;
        bad_count += q.size();
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk)
    begin
        cur = {go, hs, dec, pre, sw};
        if (rst_b && cur !== prev)
            cmp(cur, q.size() ? q.pop_front() : ~cur);
        prev = cur;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(7421));
        note(0, 0);
        cyc(3);
        rst_b = 1;
        cyc(2);
        ini = 1;
        e[9] = 1;
        note(0, 0);
        cyc(1);
        ini = 0;
        repeat (12)
        begin
            k = $urandom_range(7);
            st[k] = ~st[k];
            lvl();
        end
        st = 0;
        lvl();
        wr(16'hfeef);
        for (k = 0; k < 4; k++)
        begin
            en = 4'hc ^ (4'h1 << k);
            wr(16'h0010);
            wr(16'h0000);
        end
        en = 4'hc;
        eh = 1;
        note(0, 0);
        wr(16'h0100);
        wr(16'h0110);
        eh = 0;
        note(0, 0);
        wr(16'h0000);
        for (k = 0; k < 3; k++)
        begin
            e[13:10] = 4'b0000;
            eg = 1;
            note(0, 0);
            wr(16'h0010);
            hf = (k == 0);
            at_rest = (k == 1);
            al = (k == 2);
            eg = 0;
            if (k == 1)
                note(1, 0);
            e[13:10] = k == 0 ? 4'b0101 : k == 1 ? 4'b0001 : 4'b1001;
            note(0, k == 0);
            if (k == 0)
                note(0, 0);
            if (k == 1)
                wr(16'h0000);
            cyc(3);
            {hf, at_rest, al} = 3'b000;
            wr(16'h0000);
        end
        // Halt during a run, then an alarm while stopping
        e[13:10] = 4'b0000;
        eg = 1;
        note(0, 0);
        wr(16'h0010);
        eh = 1;
        note(0, 0);
        eg = 0;
        note(1, 0);
        wr(16'h0110);
        al = 1;
        e[13:10] = 4'b1001;
        note(0, 0);
        cyc(2);
        al = 0;
        eh = 0;
        note(0, 0);
        wr(16'h0000);
        report_and_stop();
    end
endmodule
